// ### lia_params.svh
`ifndef LIA_PARAMS_SVH
`define LIA_PARAMS_SVH

// Register word offsets, and eight-word group numbers for the bases, on the plain register port
`define LIA_ID_ADDR 8'h02
`define LIA_TASK_PRIO_ADDR 8'h08
`define LIA_PROC_PRIO_ADDR 8'h0A
`define LIA_END_OF_SERVICE_ADDR 8'h0B
`define LIA_CONFIG_ADDR 8'h0F
`define LIA_IN_SERVICE_BASE 5'h02
`define LIA_TRIGGER_BASE 5'h03
`define LIA_PENDING_BASE 5'h04

// Field positions
`define LIA_CONFIG_BUS_VARIANT 0
`define LIA_CLASS_MSB 7
`define LIA_CLASS_LSB 4

// Reset values
`define LIA_ID_RESET 8'h00
`define LIA_TASK_PRIO_RESET 8'h00
`define LIA_CONFIG_RESET 1'h0

// Interrupt-bus variant queues at most this many per priority class
`define LIA_SLOTS_PER_CLASS 5'h02

`endif

// ### lia_pkg.sv
package lia_pkg;

	typedef enum logic [3:0] {
		LIA_MODE_FIXED,
		LIA_MODE_LOWEST,
		LIA_MODE_SMI,
		LIA_MODE_NMI,
		LIA_MODE_INIT,
		LIA_MODE_INIT_DEASSERT,
		LIA_MODE_STARTUP,
		LIA_MODE_EXTERNAL_LEGACY_REQUEST,
		LIA_MODE_BOOT,
		LIA_MODE_FINAL_BOOT
	} lia_mode_t;

	typedef enum logic [1:0] {
		LIA_ST_IDLE,
		LIA_ST_ARB
	} lia_state_t;

endpackage

// ### lia_prio_enc.sv
`timescale 1ns/100ps
`default_nettype none

// Finds the highest set bit of a 256-bit vector; index 8'h00 when none.
// Highest index is highest priority: class in the upper nibble, rank in
// the lower nibble, so a plain top-down search orders both at once.
module lia_prio_enc (
	input wire logic [255:0] bits,
	output logic any,
	output logic [7:0] index
);

	always_comb begin
		any = 1'b0;
		index = 8'h00;
		for (int i = 0; i < 256; i++) begin
			if (bits[i]) begin
				any = 1'b1;
				index = 8'(i);
			end
		end
	end

endmodule

`default_nettype wire

// ### lia_accept.sv
// Operation
// - Accept a message only when this unit is the addressed destination.
// - System bus: special delivery modes go straight to the core.
// - Interrupt bus: also deassert, boot and final boot messages go direct.
// - System bus: other accepted interrupts set their pending bit.
// - Interrupt bus: queue fixed interrupt in a free slot, else retry.
// - Interrupt bus: lowest-priority messages arbitrate before acceptance.
// - Dispatch queued interrupts one at a time by priority and gating.
// - End-of-service write retires in-service entry; level sends message.
// - Priority class is vector divided by sixteen.
// - Within a class a larger vector ranks higher.
// - Task priority is software readable and writable.
// - Only interrupts above the task priority are delivered.
// - Task priority feeds the arbitration priority.
// - Processor priority is read-only and gates dispatch.
// - Processor priority is task priority or top in-service class.
// - Top in-service vector is highest set bit, else zero.
// - Core ready: move top pending bit to in-service and dispatch.
// - End-of-service clears top in-service bit, then next dispatches.
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "lia_params.svh"

module lia_accept (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic msg_valid,
	output logic msg_ready,
	input wire logic [7:0] msg_dest,
	input wire logic msg_broadcast,
	input wire lia_pkg::lia_mode_t msg_mode,
	input wire logic [7:0] msg_vector,
	input wire logic msg_level,
	output logic arb_req,
	output logic [7:0] arb_prio,
	input wire logic arb_won,
	input wire logic arb_lost,
	output logic retry_valid,
	output logic [7:0] retry_vector,
	output logic core_special_valid,
	output lia_pkg::lia_mode_t core_special_mode,
	output logic [7:0] core_special_vector,
	input wire logic core_ready,
	output logic core_int_valid,
	output logic [7:0] core_int_vector,
	output logic eos_msg_valid,
	output logic [7:0] eos_msg_vector
);

	////////////////////////////////////////////////////////////////////
	// State

	lia_pkg::lia_state_t state;
	lia_pkg::lia_state_t next_state;
	logic [255:0] pending_request_bits;
	logic [255:0] in_service_bits;
	logic [255:0] trigger_bits;
	logic [255:0] next_pending;
	logic [255:0] next_in_service;
	logic [255:0] next_trigger;
	logic [7:0] task_priority_value;
	logic [7:0] own_id;
	logic bus_variant;
	logic [7:0] held_vector;
	logic held_level;

	////////////////////////////////////////////////////////////////////
	// Register decode

	wire logic wr_id = reg_wr && reg_addr == `LIA_ID_ADDR;
	wire logic wr_task = reg_wr && reg_addr == `LIA_TASK_PRIO_ADDR;
	wire logic wr_config = reg_wr && reg_addr == `LIA_CONFIG_ADDR;
	wire logic end_of_service_write = reg_wr &&
		reg_addr == `LIA_END_OF_SERVICE_ADDR;
	wire logic [4:0] rd_group = reg_addr[7:3];
	wire logic [2:0] rd_word = reg_addr[2:0];

	////////////////////////////////////////////////////////////////////
	// Priority search

	logic pend_any;
	logic [7:0] pend_top;
	logic isv_any;
	logic [7:0] top_in_service_vector;

	lia_prio_enc u_pend_enc (
		.bits(pending_request_bits),
		.any(pend_any),
		.index(pend_top)
	);

	// Encoder yields 8'h00 when nothing is in service
	lia_prio_enc u_isv_enc (
		.bits(in_service_bits),
		.any(isv_any),
		.index(top_in_service_vector)
	);

	wire logic [3:0] task_class =
		task_priority_value[`LIA_CLASS_MSB:`LIA_CLASS_LSB];
	wire logic [3:0] isv_class =
		top_in_service_vector[`LIA_CLASS_MSB:`LIA_CLASS_LSB];
	wire logic [3:0] pend_class =
		pend_top[`LIA_CLASS_MSB:`LIA_CLASS_LSB];
	wire logic task_wins = task_class >= isv_class;

	// Processor priority is pure logic so it can never go stale
	wire logic [7:0] processor_priority_value = task_wins ?
		task_priority_value : {isv_class, 4'h0};

	////////////////////////////////////////////////////////////////////
	// Arbitration priority for lowest-priority delivery

	wire logic [3:0] pend_top_class = pend_any ? pend_class : 4'h0;
	wire logic [3:0] masked_isv = task_class & isv_class;
	wire logic [3:0] arb_class = masked_isv > pend_top_class ?
		masked_isv : pend_top_class;

	assign arb_prio = task_class >= pend_top_class ?
		task_priority_value : {arb_class, 4'h0};
	assign arb_req = state == lia_pkg::LIA_ST_ARB;

	////////////////////////////////////////////////////////////////////
	// Message classification

	wire logic is_dest = msg_broadcast || msg_dest == own_id;
	wire logic take = msg_valid && msg_ready;
	wire logic accept = take && is_dest;

	wire logic sys_direct = msg_mode == lia_pkg::LIA_MODE_NMI ||
		msg_mode == lia_pkg::LIA_MODE_SMI ||
		msg_mode == lia_pkg::LIA_MODE_INIT ||
		msg_mode == lia_pkg::LIA_MODE_EXTERNAL_LEGACY_REQUEST ||
		msg_mode == lia_pkg::LIA_MODE_STARTUP;
	wire logic ibus_direct = msg_mode == lia_pkg::LIA_MODE_INIT_DEASSERT ||
		msg_mode == lia_pkg::LIA_MODE_BOOT ||
		msg_mode == lia_pkg::LIA_MODE_FINAL_BOOT;
	wire logic is_direct = sys_direct ||
		(bus_variant && ibus_direct);
	wire logic need_arb = bus_variant &&
		msg_mode == lia_pkg::LIA_MODE_LOWEST;

	wire logic direct_go = accept && is_direct;
	wire logic arb_start = accept && !is_direct && need_arb;
	wire logic plain_enq = accept && !is_direct && !need_arb;
	wire logic arb_enq = arb_req && arb_won;

	////////////////////////////////////////////////////////////////////
	// Enqueue path

	wire logic enq_valid = plain_enq || arb_enq;
	wire logic [7:0] enq_vector = arb_req ? held_vector : msg_vector;
	wire logic enq_level = arb_req ? held_level : msg_level;
	wire logic [3:0] enq_class = enq_vector[`LIA_CLASS_MSB:`LIA_CLASS_LSB];
	wire logic [15:0] class_pend =
		pending_request_bits[{enq_class, 4'h0} +: 16];
	wire logic [15:0] class_isv = in_service_bits[{enq_class, 4'h0} +: 16];
	wire logic [4:0] class_used =
		5'($countones(class_pend)) + 5'($countones(class_isv));

	// System bus collapses repeats into the one pending bit
	wire logic slot_free = !bus_variant ||
		class_used < `LIA_SLOTS_PER_CLASS;
	wire logic enq_set = enq_valid && slot_free;
	wire logic enq_retry = enq_valid && !slot_free;

	////////////////////////////////////////////////////////////////////
	// Dispatch and retirement

	// Class gate against processor priority also covers the task gate,
	// since processor priority never falls below task priority
	wire logic dispatch_ok = pend_any &&
		pend_class > processor_priority_value[7:4];
	wire logic dispatch = core_ready && dispatch_ok;
	wire logic retire = end_of_service_write && isv_any;

	wire logic [255:0] enq_mask = enq_set ?
		256'h1 << enq_vector : 256'h0;
	wire logic [255:0] disp_mask = dispatch ?
		256'h1 << pend_top : 256'h0;
	wire logic [255:0] ret_mask = retire ?
		256'h1 << top_in_service_vector : 256'h0;

	// New arrival wins over the dispatch clear of the same vector
	assign next_pending = (pending_request_bits & ~disp_mask) |
		enq_mask;
	assign next_in_service = (in_service_bits & ~ret_mask) |
		disp_mask;
	assign next_trigger = enq_set ?
		(trigger_bits & ~enq_mask) | (enq_level ? enq_mask : 256'h0) :
		trigger_bits;

	////////////////////////////////////////////////////////////////////
	// Sequencing

	assign msg_ready = state == lia_pkg::LIA_ST_IDLE;

	always_comb begin
		next_state = state;
		unique case (state)
			lia_pkg::LIA_ST_IDLE: begin
				if (arb_start) begin
					next_state = lia_pkg::LIA_ST_ARB;
				end
			end
			lia_pkg::LIA_ST_ARB: begin
				// A loss drops the message; the winner takes it
				if (arb_won || arb_lost) begin
					next_state = lia_pkg::LIA_ST_IDLE;
				end
			end
			default: begin
				next_state = lia_pkg::LIA_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= lia_pkg::LIA_ST_IDLE;
			held_vector <= 8'h00;
			held_level <= 1'b0;
		end else begin
			state <= next_state;
			if (arb_start) begin
				held_vector <= msg_vector;
				held_level <= msg_level;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Queues

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pending_request_bits <= 256'h0;
			in_service_bits <= 256'h0;
			trigger_bits <= 256'h0;
		end else begin
			pending_request_bits <= next_pending;
			in_service_bits <= next_in_service;
			trigger_bits <= next_trigger;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Software registers

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			task_priority_value <= `LIA_TASK_PRIO_RESET;
			own_id <= `LIA_ID_RESET;
			bus_variant <= `LIA_CONFIG_RESET;
		end else begin
			if (wr_task) begin
				task_priority_value <= reg_wdata[7:0];
			end
			if (wr_id) begin
				own_id <= reg_wdata[7:0];
			end
			if (wr_config) begin
				bus_variant <= reg_wdata[`LIA_CONFIG_BUS_VARIANT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read data

	logic [31:0] rd_value;

	always_comb begin
		rd_value = 32'h0;
		unique case (rd_group)
			`LIA_IN_SERVICE_BASE: begin
				rd_value = in_service_bits[{rd_word, 5'h00} +: 32];
			end
			`LIA_TRIGGER_BASE: begin
				rd_value = trigger_bits[{rd_word, 5'h00} +: 32];
			end
			`LIA_PENDING_BASE: begin
				rd_value = pending_request_bits[{rd_word, 5'h00} +: 32];
			end
			default: begin
				unique case (reg_addr)
					`LIA_ID_ADDR: begin
						rd_value = {24'h0, own_id};
					end
					`LIA_TASK_PRIO_ADDR: begin
						rd_value = {24'h0, task_priority_value};
					end
					`LIA_PROC_PRIO_ADDR: begin
						rd_value = {24'h0, processor_priority_value};
					end
					`LIA_CONFIG_ADDR: begin
						rd_value = {31'h0, bus_variant};
					end
					default: begin
						rd_value = 32'h0;
					end
				endcase
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 32'h0;
		end else begin
			reg_rdata <= reg_rd ? rd_value : 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outgoing pulses

	// Level completion needs the trigger bit of the vector being retired
	wire logic eos_level = retire && trigger_bits[top_in_service_vector];

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			core_special_valid <= 1'b0;
			core_special_mode <= lia_pkg::LIA_MODE_FIXED;
			core_special_vector <= 8'h00;
			core_int_valid <= 1'b0;
			core_int_vector <= 8'h00;
			retry_valid <= 1'b0;
			retry_vector <= 8'h00;
			eos_msg_valid <= 1'b0;
			eos_msg_vector <= 8'h00;
		end else begin
			core_special_valid <= direct_go;
			if (direct_go) begin
				core_special_mode <= msg_mode;
				core_special_vector <= msg_vector;
			end
			core_int_valid <= dispatch;
			if (dispatch) begin
				core_int_vector <= pend_top;
			end
			retry_valid <= enq_retry;
			if (enq_retry) begin
				retry_vector <= enq_vector;
			end
			eos_msg_valid <= eos_level;
			if (eos_level) begin
				eos_msg_vector <= top_in_service_vector;
			end
		end
	end

endmodule

`default_nettype wire

// ### lia_accept_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "lia_params.svh"
module lia_accept_properties (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic msg_valid,
	input wire logic msg_ready,
	input wire lia_pkg::lia_mode_t msg_mode,
	input wire logic arb_req,
	input wire logic arb_won,
	input wire logic arb_lost,
	input wire logic retry_valid,
	input wire logic core_special_valid,
	input wire lia_pkg::lia_mode_t core_special_mode,
	input wire logic core_ready,
	input wire logic core_int_valid,
	input wire logic eos_msg_valid
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
////////////////////////////////////////////////////////////////////////
	a_arb_cause: assert property ($rose(arb_req) |->
		$past(msg_valid && msg_ready &&
		msg_mode == lia_pkg::LIA_MODE_LOWEST))
		else $error("arbitration without lowest-priority message");
	a_arb_hold: assert property (arb_req && !arb_won && !arb_lost
		|=> arb_req)
		else $error("arbitration dropped early");
	a_arb_end: assert property (arb_req && (arb_won || arb_lost)
		|=> !arb_req)
		else $error("arbitration not ended");
	a_special_src: assert property (core_special_valid |->
		$past(msg_valid && msg_ready) &&
		core_special_mode == $past(msg_mode))
		else $error("direct route without message");
	a_special_excl: assert property (
		core_special_valid |-> !retry_valid)
		else $error("direct message also retried");
	a_retry_src: assert property (retry_valid |->
		$past(msg_valid && msg_ready || arb_won))
		else $error("retry without request");
	a_int_cause: assert property (core_int_valid |->
		$past(core_ready))
		else $error("dispatch while core not ready");
	a_eos_cause: assert property (eos_msg_valid |->
		$past(reg_wr && reg_addr == `LIA_END_OF_SERVICE_ADDR))
		else $error("completion without write");
	a_rdata_idle: assert property (!$past(reg_rd) |->
		reg_rdata == 32'h0)
		else $error("read data outside read");
endmodule

bind lia_accept lia_accept_properties lia_accept_properties_i (.clk, .rst_b,
	.reg_addr, .reg_wr, .reg_rd, .reg_rdata, .msg_valid, .msg_ready,
	.msg_mode, .arb_req, .arb_won, .arb_lost, .retry_valid,
	.core_special_valid, .core_special_mode, .core_ready, .core_int_valid,
	.eos_msg_valid);
`default_nettype wire

// ### lia_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module lia_core_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic go,
	input wire logic win,
	input wire logic arb_req,
	output logic core_ready,
	output logic arb_won,
	output logic arb_lost
);
	logic [1:0] wait_cnt;
	wire logic done = wait_cnt == 2'h2;
	assign core_ready = go;
	// Peers answer late on purpose so the arbitration wait is exercised
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wait_cnt <= '0;
			arb_won <= '0;
			arb_lost <= '0;
		end else begin
			wait_cnt <= (arb_req && !done && !arb_won) ? wait_cnt + 2'h1 : '0;
			arb_won <= arb_req && done && win;
			arb_lost <= arb_req && done && !win;
		end
	end
endmodule
`default_nettype wire

// ### local_interrupt_acceptance_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "lia_params.svh"
module local_interrupt_acceptance_tb;
	localparam lia_pkg::lia_mode_t FX = lia_pkg::LIA_MODE_FIXED;
	localparam lia_pkg::lia_mode_t LO = lia_pkg::LIA_MODE_LOWEST;
	localparam logic [7:0] TP = `LIA_TASK_PRIO_ADDR;
	localparam logic [7:0] PP = `LIA_PROC_PRIO_ADDR;
	localparam logic [7:0] EOS = `LIA_END_OF_SERVICE_ADDR;
	logic clk = '0, rst_b = '0, reg_wr = '0, reg_rd = '0, msg_valid = '0;
	logic msg_broadcast = '0, msg_level = '0, go = '0, win = '0;
	logic [7:0] reg_addr = '0, msg_dest = '0, msg_vector = '0;
	logic [31:0] reg_wdata = '0;
	lia_pkg::lia_mode_t msg_mode = FX;
	logic [31:0] reg_rdata;
	logic msg_ready, arb_req, arb_won, arb_lost, retry_valid, core_ready;
	logic core_special_valid, core_int_valid, eos_msg_valid;
	logic [7:0] arb_prio, retry_vector, core_special_vector, core_int_vector;
	logic [7:0] eos_msg_vector, last_vec, ap;
	lia_pkg::lia_mode_t core_special_mode;
	int err_total = 0, cmp_count = 0, cyc = 0, k = 0;
	int n_int = 0, n_sp = 0, n_rt = 0, n_eos = 0;

	lia_accept lia_accept_i (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .msg_valid, .msg_ready, .msg_dest, .msg_broadcast,
		.msg_mode, .msg_vector, .msg_level, .arb_req, .arb_prio, .arb_won,
		.arb_lost, .retry_valid, .retry_vector, .core_special_valid,
		.core_special_mode, .core_special_vector, .core_ready, .core_int_valid,
		.core_int_vector, .eos_msg_valid, .eos_msg_vector);
	lia_core_model lia_core_model_i (.clk, .rst_b, .go, .win, .arb_req,
		.core_ready, .arb_won, .arb_lost);

	always #5 clk = ~clk;
////////////////////////////////////////////////////////////////////////
	// Pulses are counted at the edge that ends their cycle
	always @(posedge clk) begin
		cyc++;
		if (core_int_valid === 1'h1) begin
			n_int++;
			last_vec = core_int_vector;
		end
		if (arb_req === 1'h1) ap = arb_prio;
		n_sp += (core_special_valid === 1'h1);
		n_rt += (retry_valid === 1'h1);
		n_eos += (eos_msg_valid === 1'h1);
		if (cyc == 5000) begin
			err_total++;
			final_report;
		end
	end
////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'h0;
		repeat (3) @(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, string nm);
		@(posedge clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1;
		chk(nm, e, reg_rdata);
	endtask
	task automatic snd(input lia_pkg::lia_mode_t m, input logic [7:0] v,
		input logic lv = 1'h0, input logic [7:0] d = 8'h05);
		@(posedge clk);
		msg_valid <= 1'h1;
		msg_mode <= m;
		msg_vector <= v;
		msg_level <= lv;
		msg_dest <= d;
		do @(posedge clk); while (msg_ready !== 1'h1);
		msg_valid <= 1'h0;
		repeat (9) @(posedge clk);
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'h1;
		rd(TP, 32'h0, "task prio");
		rd(PP, 32'h0, "proc prio");
		rd(8'h01, 32'h0, "unmapped");
		$display("reset test done");
		wr(`LIA_ID_ADDR, 32'h05);
		wr(TP, 32'h40);
		rd(TP, 32'h40, "task prio");
		go <= 1'h1;
		snd(FX, 8'h41);
		snd(FX, 8'h51, 1'h0, 8'h06);
		chk("dispatches", 0, n_int);
		rd(8'h22, 32'h2, "pending w2");
		rd(PP, 32'h40, "proc prio");
		wr(TP, 32'h3F);
		chk("vector", 8'h41, last_vec);
		rd(8'h12, 32'h2, "in service w2");
		rd(PP, 32'h40, "proc prio");
		snd(FX, 8'h35);
		snd(FX, 8'h62);
		chk("vector", 8'h62, last_vec);
		chk("dispatches", 2, n_int);
		wr(EOS, 32'h0);
		rd(PP, 32'h40, "proc prio");
		wr(EOS, 32'h0);
		rd(PP, 32'h3F, "proc prio");
		wr(TP, 32'h0);
		chk("vector", 8'h35, last_vec);
		wr(EOS, 32'h0);
		go <= 1'h0;
		snd(FX, 8'h73);
		snd(FX, 8'h7A);
		go <= 1'h1;
		wr(8'h01, 32'h0);
		chk("vector", 8'h7A, last_vec);
		wr(EOS, 32'h0);
		chk("vector", 8'h73, last_vec);
		wr(EOS, 32'h0);
		$display("priority test done");
		for (int v = 0; v < 2; v++) begin
			wr(`LIA_CONFIG_ADDR, v);
			for (int m = 2; m < 10; m++) begin
				if (v == 0 && m inside {5, 8, 9}) continue;
				snd(lia_pkg::lia_mode_t'(m), {4'h2, 4'(m)});
				chk("special mode", m, core_special_mode);
				chk("spec vec", {4'h2, 4'(m)}, core_special_vector);
				chk("specials", ++k, n_sp);
			end
		end
		chk("dispatches", 5, n_int);
		$display("direct test done");
		go <= 1'h0;
		snd(FX, 8'h91);
		snd(FX, 8'h92, 1'h1);
		snd(FX, 8'h93);
		chk("retries", 1, n_rt);
		chk("retry vector", 8'h93, retry_vector);
		go <= 1'h1;
		wr(8'h01, 32'h0);
		chk("vector", 8'h92, last_vec);
		wr(EOS, 32'h0);
		chk("eos vector", 8'h92, eos_msg_vector);
		chk("vector", 8'h91, last_vec);
		wr(EOS, 32'h0);
		chk("eos count", 1, n_eos);
		$display("slot test done");
		wr(TP, 32'h50);
		win <= 1'h1;
		snd(LO, 8'hA1);
		chk("vector", 8'hA1, last_vec);
		chk("arb prio", 8'h50, ap);
		wr(EOS, 32'h0);
		win <= 1'h0;
		snd(LO, 8'hB1);
		chk("dispatches", 8, n_int);
		msg_broadcast <= 1'h1;
		snd(FX, 8'hC1, 1'h0, 8'h06);
		chk("dispatches", 9, n_int);
		chk("vector", 8'hC1, last_vec);
		$display("arbitration test done");
		final_report;
	end
endmodule
`default_nettype wire
